// file: ttc_threshold_compare.sv
/*
  Threshold registers and per-sample comparison for fourteen touch channels.
  Holds the sensor, group and channel-fourteen thresholds, the noise and lid
  fraction registers and the broadcast controls, and classifies each sample.
  Assumes the register port and the delta counts come from logic on i_mclk,
  so neither passes a synchroniser, and that wr and rd never come together.
*/
`timescale 1ns/1ps
`default_nettype none
module ttc_threshold_compare #(
  parameter int unsigned DELTA_W = ttc_pkg::TTC_DELTA_W
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire ttc_pkg::ttc_reg_req_s i_reg_req,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_ack,
  input wire logic i_sample_valid,
  input wire logic [ttc_pkg::TTC_NUM_SENSORS*DELTA_W-1:0] i_delta,
  output logic o_result_valid,
  output logic [ttc_pkg::TTC_NUM_SENSORS-1:0] o_touch,
  output logic [ttc_pkg::TTC_NUM_SENSORS-1:0] o_noise_spike,
  output logic [ttc_pkg::TTC_NUM_SENSORS-1:0] o_lid_status,
  output logic o_button_threshold_broadcast_en,
  output logic o_group_threshold_broadcast_en
);
  import ttc_pkg::*;

  // register state
  logic [7:0] recal_cfg;
  logic [TTC_THR_W-1:0] thr_btn [TTC_NUM_BUTTONS];
  logic [TTC_THR_W-1:0] thr_grp;
  logic [TTC_THR_W-1:0] thr_channel_fourteen;
  logic [7:0] noise_fraction_sensors_1_to_4;
  logic [7:0] noise_fraction_sensors_5_to_7_group;
  logic [7:0] lid_fraction_sensors_1_to_4;
  logic [7:0] lid_fraction_sensors_5_to_8;
  logic [7:0] lid_fraction_sensors_9_to_12;
  logic [TTC_LID4_W-1:0] lid_fraction_sensors_13_14;

  // write decode
  logic wr_cfg;
  logic wr_thr1;
  logic wr_grp;
  logic wr_ch14;
  logic wr_noise1;
  logic wr_noise2;
  logic wr_lid1;
  logic wr_lid2;
  logic wr_lid3;
  logic wr_lid4;
  logic [TTC_NUM_BUTTONS-1:0] wr_btn;
  logic button_threshold_broadcast_en;
  logic group_threshold_broadcast_en;

  // per-channel views
  logic [TTC_THR_W-1:0] chan_thr [TTC_NUM_SENSORS];
  logic [TTC_CODE_W-1:0] chan_noise_code [TTC_NUM_SENSORS];
  logic [TTC_CODE_W-1:0] chan_lid_code [TTC_NUM_SENSORS];
  logic [2*TTC_NUM_SENSORS-1:0] lid_codes_all;
  ttc_flags_s chan_flags [TTC_NUM_SENSORS];
  logic [TTC_NUM_SENSORS-1:0] next_touch;
  logic [TTC_NUM_SENSORS-1:0] next_noise;
  logic [TTC_NUM_SENSORS-1:0] next_lid;
  logic [7:0] next_rdata;

  // broadcast enables from the recal config
  assign button_threshold_broadcast_en = recal_cfg[TTC_BIT_BTN_BCAST];
  assign group_threshold_broadcast_en = recal_cfg[TTC_BIT_GRP_BCAST];

  // single-register write strobes
  always_comb begin
    wr_cfg = 1'b0;
    wr_grp = 1'b0;
    wr_ch14 = 1'b0;
    wr_noise1 = 1'b0;
    wr_noise2 = 1'b0;
    wr_lid1 = 1'b0;
    wr_lid2 = 1'b0;
    wr_lid3 = 1'b0;
    wr_lid4 = 1'b0;
    if (!i_reg_req.wr) begin
      wr_cfg = 1'b0;
    end else if (i_reg_req.addr == TTC_OFS_RECAL_CFG) begin
      wr_cfg = 1'b1;
    end else if (i_reg_req.addr == TTC_OFS_THR_GRP) begin
      wr_grp = 1'b1;
    end else if (i_reg_req.addr == TTC_OFS_THR_CH14) begin
      wr_ch14 = 1'b1;
    end else if (i_reg_req.addr == TTC_OFS_NOISE1) begin
      wr_noise1 = 1'b1;
    end else if (i_reg_req.addr == TTC_OFS_NOISE2) begin
      wr_noise2 = 1'b1;
    end else if (i_reg_req.addr == TTC_OFS_LID1) begin
      wr_lid1 = 1'b1;
    end else if (i_reg_req.addr == TTC_OFS_LID2) begin
      wr_lid2 = 1'b1;
    end else if (i_reg_req.addr == TTC_OFS_LID3) begin
      wr_lid3 = 1'b1;
    end else if (i_reg_req.addr == TTC_OFS_LID4) begin
      wr_lid4 = 1'b1;
    end
  end

  // the first sensor threshold is the broadcast source
  assign wr_thr1 = wr_btn[0];

  // recalibration config; bit 5 is reserved and reads zero
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      recal_cfg <= TTC_RST_RECAL_CFG;
    end else if (wr_cfg) begin
      recal_cfg <= i_reg_req.wdata & TTC_MASK_RECAL_CFG;
    end
  end

  // button thresholds: own write, or broadcast from the first one
  genvar gb;
  generate
    for (gb = 0; gb < TTC_NUM_BUTTONS; gb++) begin : g_btn
      assign wr_btn[gb] = i_reg_req.wr && (i_reg_req.addr == TTC_OFS_THR1 + 8'(gb));
      always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
          thr_btn[gb] <= TTC_RST_THR;
        end else if (wr_btn[gb]) begin
          thr_btn[gb] <= i_reg_req.wdata[TTC_THR_W-1:0];
        end else if (wr_thr1 && button_threshold_broadcast_en) begin
          thr_btn[gb] <= i_reg_req.wdata[TTC_THR_W-1:0];
        end
      end
    end
  endgenerate

  // group threshold: own write, or group broadcast
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      thr_grp <= TTC_RST_THR;
    end else if (wr_grp) begin
      thr_grp <= i_reg_req.wdata[TTC_THR_W-1:0];
    end else if (wr_thr1 && group_threshold_broadcast_en) begin
      thr_grp <= i_reg_req.wdata[TTC_THR_W-1:0];
    end
  end

  // channel fourteen threshold follows the group broadcast too
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      thr_channel_fourteen <= TTC_RST_THR;
    end else if (wr_ch14) begin
      thr_channel_fourteen <= i_reg_req.wdata[TTC_THR_W-1:0];
    end else if (wr_thr1 && group_threshold_broadcast_en) begin
      thr_channel_fourteen <= i_reg_req.wdata[TTC_THR_W-1:0];
    end
  end

  // first noise fraction register, sensors 4 down to 1
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      noise_fraction_sensors_1_to_4 <= TTC_RST_NOISE1;
    end else if (wr_noise1) begin
      noise_fraction_sensors_1_to_4 <= i_reg_req.wdata;
    end
  end

  // second noise fraction register, group then sensors 7 down to 5
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      noise_fraction_sensors_5_to_7_group <= TTC_RST_NOISE2;
    end else if (wr_noise2) begin
      noise_fraction_sensors_5_to_7_group <= i_reg_req.wdata;
    end
  end

  // first lid fraction register, sensors 4 down to 1
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      lid_fraction_sensors_1_to_4 <= TTC_RST_LID1;
    end else if (wr_lid1) begin
      lid_fraction_sensors_1_to_4 <= i_reg_req.wdata;
    end
  end

  // second lid fraction register, sensors 8 down to 5
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      lid_fraction_sensors_5_to_8 <= TTC_RST_LID2;
    end else if (wr_lid2) begin
      lid_fraction_sensors_5_to_8 <= i_reg_req.wdata;
    end
  end

  // third lid fraction register, grouped sensors 12 down to 9
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      lid_fraction_sensors_9_to_12 <= TTC_RST_LID3;
    end else if (wr_lid3) begin
      lid_fraction_sensors_9_to_12 <= i_reg_req.wdata;
    end
  end

  // fourth lid fraction register keeps only its low nibble
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      lid_fraction_sensors_13_14 <= TTC_RST_LID4;
    end else if (wr_lid4) begin
      lid_fraction_sensors_13_14 <= i_reg_req.wdata[TTC_LID4_W-1:0];
    end
  end

  // readback value for the addressed register
  always_comb begin
    next_rdata = 8'h00;
    if (i_reg_req.addr == TTC_OFS_RECAL_CFG) begin
      next_rdata = recal_cfg;
    end else if (i_reg_req.addr >= TTC_OFS_THR1 && i_reg_req.addr <= TTC_OFS_THR7) begin
      next_rdata = {1'b0, thr_btn[i_reg_req.addr[2:0]]};
    end else if (i_reg_req.addr == TTC_OFS_THR_GRP) begin
      next_rdata = {1'b0, thr_grp};
    end else if (i_reg_req.addr == TTC_OFS_THR_CH14) begin
      next_rdata = {1'b0, thr_channel_fourteen};
    end else if (i_reg_req.addr == TTC_OFS_NOISE1) begin
      next_rdata = noise_fraction_sensors_1_to_4;
    end else if (i_reg_req.addr == TTC_OFS_NOISE2) begin
      next_rdata = noise_fraction_sensors_5_to_7_group;
    end else if (i_reg_req.addr == TTC_OFS_LID1) begin
      next_rdata = lid_fraction_sensors_1_to_4;
    end else if (i_reg_req.addr == TTC_OFS_LID2) begin
      next_rdata = lid_fraction_sensors_5_to_8;
    end else if (i_reg_req.addr == TTC_OFS_LID3) begin
      next_rdata = lid_fraction_sensors_9_to_12;
    end else if (i_reg_req.addr == TTC_OFS_LID4) begin
      next_rdata = {4'h0, lid_fraction_sensors_13_14};
    end
  end

  // read data held until the next read
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_req.rd) begin
      o_reg_rdata <= next_rdata;
    end
  end

  // one-cycle acknowledge for every access, mapped or not
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_reg_ack <= 1'b0;
    end else begin
      o_reg_ack <= i_reg_req.wr || i_reg_req.rd;
    end
  end

  // button broadcast enable shown at its pin, one cycle late
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_button_threshold_broadcast_en <= TTC_RST_RECAL_CFG[TTC_BIT_BTN_BCAST];
    end else begin
      o_button_threshold_broadcast_en <= button_threshold_broadcast_en;
    end
  end

  // group broadcast enable shown at its pin, one cycle late
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_group_threshold_broadcast_en <= TTC_RST_RECAL_CFG[TTC_BIT_GRP_BCAST];
    end else begin
      o_group_threshold_broadcast_en <= group_threshold_broadcast_en;
    end
  end

  // all lid codes, sensor 1 in the low pair
  assign lid_codes_all = {lid_fraction_sensors_13_14, lid_fraction_sensors_9_to_12,
                          lid_fraction_sensors_5_to_8, lid_fraction_sensors_1_to_4};

  // per-channel base threshold, codes and compare
  genvar gc;
  generate
    for (gc = 0; gc < TTC_NUM_SENSORS; gc++) begin : g_chan
      if (gc < TTC_NUM_BUTTONS) begin : g_button
        assign chan_thr[gc] = thr_btn[gc];
      end else if (gc == TTC_NUM_SENSORS - 1) begin : g_fourteen
        assign chan_thr[gc] = thr_channel_fourteen;
      end else begin : g_grouped
        assign chan_thr[gc] = thr_grp;
      end
      if (gc < 4) begin : g_noise_lo
        assign chan_noise_code[gc] = noise_fraction_sensors_1_to_4[2*gc +: 2];
      end else if (gc < TTC_NUM_BUTTONS) begin : g_noise_hi
        assign chan_noise_code[gc] = noise_fraction_sensors_5_to_7_group[2*(gc-4) +: 2];
      end else begin : g_noise_grp
        assign chan_noise_code[gc] =
          noise_fraction_sensors_5_to_7_group[TTC_POS_GRP_NOISE +: 2];
      end
      assign chan_lid_code[gc] = lid_codes_all[2*gc +: 2];
      ttc_channel_compare #(
        .DELTA_W(DELTA_W)
      ) u_cmp (
        .i_delta(i_delta[gc*DELTA_W +: DELTA_W]),
        .i_threshold(chan_thr[gc]),
        .i_noise_code(chan_noise_code[gc]),
        .i_lid_code(chan_lid_code[gc]),
        .o_flags(chan_flags[gc])
      );
      assign next_touch[gc] = chan_flags[gc].touch;
      assign next_noise[gc] = chan_flags[gc].noise;
      assign next_lid[gc] = chan_flags[gc].lid;
    end
  endgenerate

  // touch flags captured on every completed sample
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_touch <= '0;
    end else if (i_sample_valid) begin
      o_touch <= next_touch;
    end
  end

  // noise spike flags, held until the next sample
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_noise_spike <= '0;
    end else if (i_sample_valid) begin
      o_noise_spike <= next_noise;
    end
  end

  // lid status is a per-sample level, not sticky
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_lid_status <= '0;
    end else if (i_sample_valid) begin
      o_lid_status <= next_lid;
    end
  end

  // result strobe one cycle after the sample
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_result_valid <= 1'b0;
    end else begin
      o_result_valid <= i_sample_valid;
    end
  end

endmodule // ttc_threshold_compare
`default_nettype wire

// file: ttc_pkg.sv
/*
  Package for the touch threshold compare block: register offsets, reset values,
  field positions, fraction codes and the structs that carry bus requests and
  per-channel compare flags.
  Assumes a single 10 MHz clock domain and an 8-bit register port in front of it.
*/
// Function
// - a touch is declared on a channel only when its delta count is above its own threshold.
// - with button broadcast set, a write to the first threshold also loads thresholds 31h-36h.
// - with group broadcast set, a write to 30h also loads the group threshold 37h and 40h.
// - each threshold register other than 30h, button or group, stays writable on its own without side effects.
// - a sample above the noise limit but not the touch limit is a noise spike, kept from recal.
// - a noise fraction code 00/01/10/11 selects 6.25/12.5/25/50 percent of the touch threshold.
// - the first noise register holds sensors 4..1 in bit pairs 7-6 down to 1-0.
// - the second noise register holds group in 7-6, then sensors 7, 6, 5 in 5-4, 3-2, 1-0.
// - a sensor above its lid limit sets its bit in the lid status output.
// - a lid fraction code uses the same four fractions as the noise code.
// - the first lid register holds sensors 4, 3, 2, 1 in bit pairs 7-6, 5-4, 3-2, 1-0.
// - the second lid register holds sensors 8, 7, 6, 5 in bit pairs 7-6, 5-4, 3-2, 1-0.
// - the third lid register holds sensors 12, 11, 10, 9 in bit pairs 7-6, 5-4, 3-2, 1-0.
// - the fourth lid register holds sensor 14 in bits 3-2, sensor 13 in 1-0, upper bits unused.
// - button broadcast is config bit 7, reset set; group broadcast is bit 6, reset clear.
`default_nettype none
package ttc_pkg;

  // sizes
  localparam int unsigned TTC_NUM_SENSORS = 14;
  localparam int unsigned TTC_NUM_BUTTONS = 7;
  localparam int unsigned TTC_DELTA_W = 8;
  localparam int unsigned TTC_THR_W = 7;
  localparam int unsigned TTC_CODE_W = 2;

  // register offsets
  localparam logic [7:0] TTC_OFS_RECAL_CFG = 8'h2f;
  localparam logic [7:0] TTC_OFS_THR1 = 8'h30;
  localparam logic [7:0] TTC_OFS_THR7 = 8'h36;
  localparam logic [7:0] TTC_OFS_THR_GRP = 8'h37;
  localparam logic [7:0] TTC_OFS_NOISE1 = 8'h38;
  localparam logic [7:0] TTC_OFS_NOISE2 = 8'h39;
  localparam logic [7:0] TTC_OFS_LID1 = 8'h3a;
  localparam logic [7:0] TTC_OFS_LID2 = 8'h3b;
  localparam logic [7:0] TTC_OFS_LID3 = 8'h3c;
  localparam logic [7:0] TTC_OFS_LID4 = 8'h3d;
  localparam logic [7:0] TTC_OFS_THR_CH14 = 8'h40;

  // reset values
  localparam logic [7:0] TTC_RST_RECAL_CFG = 8'h93;
  localparam logic [6:0] TTC_RST_THR = 7'h40;
  localparam logic [7:0] TTC_RST_NOISE1 = 8'haa;
  localparam logic [7:0] TTC_RST_NOISE2 = 8'haa;
  localparam logic [7:0] TTC_RST_LID1 = 8'haa;
  localparam logic [7:0] TTC_RST_LID2 = 8'haa;
  localparam logic [7:0] TTC_RST_LID3 = 8'haa;
  localparam logic [3:0] TTC_RST_LID4 = 4'ha;

  // field positions
  localparam int unsigned TTC_BIT_BTN_BCAST = 7;
  localparam int unsigned TTC_BIT_GRP_BCAST = 6;
  localparam logic [7:0] TTC_MASK_RECAL_CFG = 8'hdf;
  localparam int unsigned TTC_POS_GRP_NOISE = 6;
  localparam int unsigned TTC_LID4_W = 4;

  // fraction of the touch threshold
  typedef enum logic [1:0] {
    TTC_FRAC_SIXTEENTH = 2'h0,
    TTC_FRAC_EIGHTH = 2'h1,
    TTC_FRAC_QUARTER = 2'h2,
    TTC_FRAC_HALF = 2'h3
  } ttc_frac_e;

  // one register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ttc_reg_req_s;

  // compare results of one channel
  typedef struct packed {
    logic touch;
    logic noise;
    logic lid;
  } ttc_flags_s;

endpackage
`default_nettype wire

// file: ttc_channel_compare.sv
/*
  One channel of threshold comparison: touch, noise spike and lid limits.
  Assumes the caller registers the flags; this module is purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
module ttc_channel_compare #(
  parameter int unsigned DELTA_W = ttc_pkg::TTC_DELTA_W
) (
  input wire logic [DELTA_W-1:0] i_delta,
  input wire logic [ttc_pkg::TTC_THR_W-1:0] i_threshold,
  input wire logic [ttc_pkg::TTC_CODE_W-1:0] i_noise_code,
  input wire logic [ttc_pkg::TTC_CODE_W-1:0] i_lid_code,
  output ttc_pkg::ttc_flags_s o_flags
);
  import ttc_pkg::*;

  logic [TTC_THR_W-1:0] noise_limit;
  logic [TTC_THR_W-1:0] lid_limit;

  // fraction of the threshold by right shift
  function automatic logic [TTC_THR_W-1:0] frac_of(input logic [TTC_THR_W-1:0] thr,
                                                   input logic [TTC_CODE_W-1:0] code);
    logic [TTC_THR_W-1:0] res;
    res = thr >> 4;
    case (ttc_frac_e'(code))
      TTC_FRAC_SIXTEENTH: res = thr >> 4;
      TTC_FRAC_EIGHTH: res = thr >> 3;
      TTC_FRAC_QUARTER: res = thr >> 2;
      TTC_FRAC_HALF: res = thr >> 1;
      default: res = thr >> 2;
    endcase
    return res;
  endfunction

  // limits for this channel
  assign noise_limit = frac_of(i_threshold, i_noise_code);
  assign lid_limit = frac_of(i_threshold, i_lid_code);

  // the three comparisons
  always_comb begin
    o_flags.touch = i_delta > DELTA_W'(i_threshold);
    o_flags.noise = (i_delta > DELTA_W'(noise_limit)) && !o_flags.touch;
    o_flags.lid = i_delta > DELTA_W'(lid_limit);
  end

endmodule // ttc_channel_compare
`default_nettype wire

// file: ttc_threshold_compare_checker.sv
/*
  port checker for ttc_threshold_compare: handshake timing and flag relations.
  assumes a bind to every instance and one clock domain on i_mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module ttc_threshold_compare_checker #(
  parameter int unsigned DELTA_W = ttc_pkg::TTC_DELTA_W
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire ttc_pkg::ttc_reg_req_s i_reg_req,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_ack,
  input wire logic i_sample_valid,
  input wire logic [ttc_pkg::TTC_NUM_SENSORS*DELTA_W-1:0] i_delta,
  input wire logic o_result_valid,
  input wire logic [ttc_pkg::TTC_NUM_SENSORS-1:0] o_touch,
  input wire logic [ttc_pkg::TTC_NUM_SENSORS-1:0] o_noise_spike,
  input wire logic [ttc_pkg::TTC_NUM_SENSORS-1:0] o_lid_status,
  input wire logic o_button_threshold_broadcast_en,
  input wire logic o_group_threshold_broadcast_en
);
  import ttc_pkg::*;
  logic [TTC_NUM_SENSORS-1:0] big;
  logic [TTC_NUM_SENSORS-1:0] zero;
  logic cfg_wr;
  // delta above any 7-bit threshold, or exactly zero
  always_comb begin
    for (int k = 0; k < TTC_NUM_SENSORS; k++) begin
      big[k] = i_delta[k*DELTA_W+DELTA_W-1];
      zero[k] = (i_delta[k*DELTA_W +: DELTA_W] == '0);
    end
  end
  assign cfg_wr = i_reg_req.wr && (i_reg_req.addr == TTC_OFS_RECAL_CFG);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  a_ack_after_req: assert property ((i_reg_req.wr || i_reg_req.rd) |=> o_reg_ack)
    else $error("register ack missing after request");
  a_ack_no_req: assert property (!(i_reg_req.wr || i_reg_req.rd) |=> !o_reg_ack)
    else $error("register ack without request");
  a_result_one_pulse: assert property (
    i_sample_valid ##1 !i_sample_valid |-> o_result_valid ##1 !o_result_valid)
    else $error("result valid not a single pulse after sample");
  a_flags_hold_idle: assert property (!i_sample_valid |=>
    $stable(o_touch) && $stable(o_noise_spike) && $stable(o_lid_status))
    else $error("flags changed without a sample");
  a_big_delta_touch: assert property (
    i_sample_valid |=> (o_touch & $past(big)) == $past(big))
    else $error("large delta not reported as touch");
  a_zero_delta_quiet: assert property (i_sample_valid |=>
    ((o_touch | o_noise_spike | o_lid_status) & $past(zero)) == '0)
    else $error("zero delta raised a flag");
  a_noise_not_touch: assert property ((o_noise_spike & o_touch) == '0)
    else $error("noise spike set on a touched sensor");
  a_touch_sets_lid: assert property ((o_touch & ~o_lid_status) == '0)
    else $error("touched sensor without lid status");
  a_bcast_mirror: assert property (
    cfg_wr ##1 !cfg_wr [*2] |=> o_button_threshold_broadcast_en == $past(i_reg_req.wdata[7], 3)
    && o_group_threshold_broadcast_en == $past(i_reg_req.wdata[6], 3))
    else $error("broadcast enables do not follow config write");
  a_lid4_upper_zero: assert property (
    i_reg_req.rd && i_reg_req.addr == TTC_OFS_LID4 |=> o_reg_rdata[7:4] == 4'h0)
    else $error("unused lid bits read nonzero");
  c_noise_seen: cover property (i_sample_valid ##1 (|o_noise_spike));
  c_lid_only: cover property (|(o_lid_status & ~o_touch));
  c_cfg_write: cover property (cfg_wr);
endmodule // ttc_threshold_compare_checker
bind ttc_threshold_compare ttc_threshold_compare_checker #(.DELTA_W(DELTA_W))
  ttc_threshold_compare_checker_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_reg_req(i_reg_req),
  .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack), .i_sample_valid(i_sample_valid),
  .i_delta(i_delta), .o_result_valid(o_result_valid), .o_touch(o_touch),
  .o_noise_spike(o_noise_spike), .o_lid_status(o_lid_status),
  .o_button_threshold_broadcast_en(o_button_threshold_broadcast_en),
  .o_group_threshold_broadcast_en(o_group_threshold_broadcast_en));
`default_nettype wire

// file: touch_threshold_compare_test.sv
/*
  self-checking bench for ttc_threshold_compare: register reset values,
  broadcast loading, field layouts and per-sample compare flags.
  assumes the one-cycle strobe register port and 8-bit deltas.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
  end
module touch_threshold_compare_test;
  import ttc_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  ttc_reg_req_s i_reg_req = '0;
  logic i_sample_valid = 1'b0;
  logic [TTC_NUM_SENSORS*8-1:0] i_delta = '0;
  logic [7:0] o_reg_rdata;
  logic o_reg_ack;
  logic o_result_valid;
  logic [TTC_NUM_SENSORS-1:0] o_touch;
  logic [TTC_NUM_SENSORS-1:0] o_noise_spike;
  logic [TTC_NUM_SENSORS-1:0] o_lid_status;
  logic o_btn_bcast;
  logic o_grp_bcast;
  int fails = 0;
  int checked = 0;
  // per-sensor threshold and fraction codes the bench has programmed
  logic [6:0] thr [TTC_NUM_SENSORS];
  logic [1:0] ncode [TTC_NUM_SENSORS] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1, 2'h0,
                                          2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
  logic [1:0] lcode [TTC_NUM_SENSORS] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3,
                                          2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h1};

  ttc_threshold_compare ttc_threshold_compare_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack),
    .i_sample_valid(i_sample_valid), .i_delta(i_delta), .o_result_valid(o_result_valid),
    .o_touch(o_touch), .o_noise_spike(o_noise_spike), .o_lid_status(o_lid_status),
    .o_button_threshold_broadcast_en(o_btn_bcast), .o_group_threshold_broadcast_en(o_grp_bcast));

  // 10 mhz clock
  initial begin
    forever #50 i_mclk = ~i_mclk;
  end

  task automatic wrap_up();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // one register strobe, held until the taking edge, then wait for ack
  task automatic reg_access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                            output logic [7:0] rdata);
    int n;
    @(posedge i_mclk);
    i_reg_req <= '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
    @(posedge i_mclk);
    i_reg_req <= '0;
    n = 0;
    #1;
    while (o_reg_ack !== 1'b1 && n < 4) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    if (o_reg_ack !== 1'b1) begin
      fails++;
      $display("mismatch register ack expected 1 seen none");
      wrap_up();
    end
    rdata = o_reg_rdata;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    reg_access(1'b1, addr, data, d);
  endtask

  task automatic chk_rd(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    reg_access(1'b0, addr, 8'h00, d);
    `CHK($sformatf("register %h", addr), exp, d)
  endtask

  // one sample; expected flags from the programmed thresholds and codes
  task automatic sample_chk(input logic [TTC_NUM_SENSORS*8-1:0] d);
    logic [TTC_NUM_SENSORS-1:0] et;
    logic [TTC_NUM_SENSORS-1:0] en;
    logic [TTC_NUM_SENSORS-1:0] el;
    int v;
    for (int k = 0; k < TTC_NUM_SENSORS; k++) begin
      v = d[k*8 +: 8];
      et[k] = v > thr[k];
      en[k] = (v > (thr[k] >> (4 - ncode[k]))) && !et[k];
      el[k] = v > (thr[k] >> (4 - lcode[k]));
    end
    @(posedge i_mclk);
    i_sample_valid <= 1'b1;
    i_delta <= d;
    @(posedge i_mclk);
    i_sample_valid <= 1'b0;
    #1;
    `CHK("result valid", 1'b1, o_result_valid)
    `CHK("touch flags", et, o_touch)
    `CHK("noise flags", en, o_noise_spike)
    `CHK("lid flags", el, o_lid_status)
  endtask

  // every sensor sits at and just above each of its limits
  task automatic sweep();
    logic [TTC_NUM_SENSORS*8-1:0] d;
    for (int s = 0; s <= 4; s++) begin
      for (int o = 0; o <= 1; o++) begin
        for (int k = 0; k < TTC_NUM_SENSORS; k++) begin
          d[k*8 +: 8] = 8'((thr[k] >> s) + o);
        end
        sample_chk(d);
      end
    end
    sample_chk('0);
    sample_chk({TTC_NUM_SENSORS{8'hff}});
  endtask

  // reset values over 2fh..41h, unmapped places read zero
  task automatic check_reset();
    logic [7:0] e;
    `CHK("button bcast", 1'b1, o_btn_bcast)
    `CHK("group bcast", 1'b0, o_grp_bcast)
    for (int a = 8'h2f; a <= 8'h41; a++) begin
      e = (a == 8'h2f) ? 8'h93 : (a <= 8'h37) ? 8'h40 : (a <= 8'h3c) ? 8'haa :
          (a == 8'h3d) ? 8'h0a : (a == 8'h40) ? 8'h40 : 8'h00;
      chk_rd(8'(a), e);
    end
  endtask

  // distinct codes per sensor expose any swapped field
  task automatic check_fields();
    wr(TTC_OFS_NOISE1, 8'he4);
    wr(TTC_OFS_NOISE2, 8'h1b);
    wr(TTC_OFS_LID1, 8'h1b);
    wr(TTC_OFS_LID2, 8'he4);
    wr(TTC_OFS_LID3, 8'h4e);
    wr(TTC_OFS_LID4, 8'hf6);
    chk_rd(TTC_OFS_LID4, 8'h06);
    chk_rd(TTC_OFS_NOISE2, 8'h1b);
    sweep();
  endtask

  // button broadcast by default, then group broadcast only
  task automatic check_broadcast();
    wr(TTC_OFS_THR1, 8'h95);
    for (int a = 8'h31; a <= 8'h36; a++) begin
      chk_rd(8'(a), 8'h15);
    end
    chk_rd(TTC_OFS_THR_GRP, 8'h40);
    chk_rd(TTC_OFS_THR_CH14, 8'h40);
    wr(TTC_OFS_RECAL_CFG, 8'h73); // reserved bit 5 set, must read back clear
    chk_rd(TTC_OFS_RECAL_CFG, 8'h53);
    `CHK("button bcast", 1'b0, o_btn_bcast)
    `CHK("group bcast", 1'b1, o_grp_bcast)
    wr(TTC_OFS_THR1, 8'h22);
    chk_rd(8'h31, 8'h15);
    chk_rd(TTC_OFS_THR_GRP, 8'h22);
    chk_rd(TTC_OFS_THR_CH14, 8'h22);
    wr(8'h33, 8'h11);
    wr(TTC_OFS_THR_GRP, 8'h30);
    chk_rd(TTC_OFS_THR1, 8'h22);
    chk_rd(8'h33, 8'h11);
    chk_rd(TTC_OFS_THR_CH14, 8'h22);
    for (int k = 0; k < TTC_NUM_SENSORS; k++) begin
      thr[k] = (k == 0 || k == 13) ? 7'h22 : (k == 3) ? 7'h11 : (k < 7) ? 7'h15 : 7'h30;
    end
    sweep();
  endtask

  // main sequence
  initial begin
    for (int k = 0; k < TTC_NUM_SENSORS; k++) begin
      thr[k] = 7'h40;
    end
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    #1;
    check_reset();
    check_fields();
    check_broadcast();
    wrap_up();
  end
endmodule // touch_threshold_compare_test
`default_nettype wire
